// ### core/wire_off_pkg.sv
// Purpose: shared constants for the analog input wire-off detect block
// Assumes: 16 channel slots, 16-bit integer data, 32-bit float data
// Notes: register offsets are byte addresses on an AHB-Lite slave
package wire_off_pkg;
  localparam int NUM_CH = 16;
  localparam int CH_W = 4;
  // register byte offsets
  localparam logic [7:0] CONFIG_OFF = 8'h00;
  localparam logic [7:0] FAULT_OFF = 8'h04;
  localparam logic [7:0] BELOW_OFF = 8'h08;
  localparam logic [7:0] ABOVE_OFF = 8'h0C;
  localparam logic [7:0] FMIN_OFF = 8'h10;
  localparam logic [7:0] FMAX_OFF = 8'h14;
  localparam logic [7:0] DATA_BASE = 8'h40;
  // config fields
  localparam int CFG_DIFF_BIT = 0;
  localparam int CFG_CURR_BIT = 1;
  localparam int CFG_FLOAT_BIT = 2;
  localparam int CFG_HS_BIT = 3;
  localparam logic [3:0] CONFIG_RST = 4'h0;
  // substituted integer counts
  localparam logic [31:0] INT_SE_MIN = 32'hFFFF8001; // -32,767
  localparam logic [31:0] INT_SE_MAX = 32'h00007FFF; // 32,767
  localparam logic [31:0] INT_CUR_MIN = 32'hFFFF8000; // -32,768
  localparam logic [31:0] INT_DIFF_MAX = 32'h00008000; // 32,768
  // float scaled limits, written by software
  localparam logic [31:0] FMIN_RST = 32'h00000000;
  localparam logic [31:0] FMAX_RST = 32'h00000000;
  // ahb codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// ### core/wire_off_channel.sv
// Purpose: per-channel wire-off substitution and range flags
// Assumes: inputs are synchronous, data update strobe is one cycle
// Notes: one instance per channel slot
`timescale 1ns/1ps
module wire_off_channel (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // configuration
  input wire logic diff_in,
  input wire logic curr_in,
  input wire logic float_in,
  input wire logic odd_in,
  input wire logic [31:0] fmin_in,
  input wire logic [31:0] fmax_in,
  // sample
  input wire logic upd_in,
  input wire logic sig_off_in,
  input wire logic full_off_in,
  input wire logic [31:0] raw_in,
  input wire logic raw_below_in,
  input wire logic raw_above_in,
  // results
  output logic [31:0] data_out,
  output logic below_out,
  output logic above_out
);
  import wire_off_pkg::*;
  logic use_max; // substitute maximum
  logic off; // any wire-off seen
  // pick min or max per wiring mode
  always_comb begin
    off = sig_off_in | full_off_in;
    if (curr_in) begin
      use_max = full_off_in;
    end else if (diff_in) begin
      use_max = 1'b1;
    end else begin
      use_max = ~odd_in;
    end
  end
  // data and flags refresh every update
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_out <= 32'h00000000;
      below_out <= 1'b0;
      above_out <= 1'b0;
    end else if (ce_in && upd_in) begin
      if (off) begin
        below_out <= ~use_max;
        above_out <= use_max;
        if (float_in) begin
          data_out <= use_max ? fmax_in : fmin_in;
        end else if (curr_in) begin
          data_out <= use_max ? INT_DIFF_MAX : INT_CUR_MIN;
        end else if (diff_in) begin
          data_out <= INT_DIFF_MAX;
        end else begin
          data_out <= use_max ? INT_SE_MAX : INT_SE_MIN;
        end
      end else begin
        data_out <= raw_in;
        below_out <= raw_below_in;
        above_out <= raw_above_in;
      end
    end
  end
  flag_excl_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !(below_out && above_out)) else $error("both range flags set");
  se_odd_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && upd_in && sig_off_in && !full_off_in && !diff_in && !curr_in && odd_in
     && !float_in) |=> (below_out && data_out == INT_SE_MIN))
    else $error("odd single-ended wire-off wrong");
  se_even_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && upd_in && off && !diff_in && !curr_in && !odd_in && !float_in)
    |=> (above_out && data_out == INT_SE_MAX)) else $error("even single-ended wrong");
  cur_sig_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && upd_in && curr_in && sig_off_in && !full_off_in && !float_in)
    |=> (below_out && data_out == INT_CUR_MIN)) else $error("current wire-off wrong");
  diff_v_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && upd_in && off && diff_in && !curr_in && !float_in)
    |=> (above_out && data_out == INT_DIFF_MAX)) else $error("diff wire-off wrong");
  cur_full_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && upd_in && curr_in && full_off_in && float_in)
    |=> (above_out && data_out == $past(fmax_in))) else $error("open current wrong");
  clear_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && upd_in && !off) |=> (data_out == $past(raw_in)))
    else $error("valid reading not restored");
  hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !(ce_in && upd_in) |=> $stable(data_out)) else $error("data moved without update");
  off_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) ce_in && upd_in && off);
  back_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    below_out ##1 (ce_in && upd_in && !off) ##1 !below_out);
  full_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && upd_in && curr_in && full_off_in);
endmodule // wire_off_channel

// ### core/wire_off_detect.sv
// Purpose: wire-off detect top with AHB-Lite register slave
// Assumes: wire-off pins are asynchronous, sample data is core-clock synchronous
// Notes: writes take effect at data phase; zero wait states
`timescale 1ns/1ps
module wire_off_detect (
  // clock, reset, enable
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [7:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // field-side detectors, asynchronous
  input wire logic [wire_off_pkg::NUM_CH-1:0] sig_wire_off_in,
  input wire logic [wire_off_pkg::NUM_CH-1:0] removable_terminal_block_off_in,
  // converter samples
  input wire logic sample_valid_in,
  input wire logic [wire_off_pkg::CH_W-1:0] sample_ch_in,
  input wire logic [31:0] sample_data_in,
  input wire logic sample_below_in,
  input wire logic sample_above_in,
  // to owner controller
  output logic [wire_off_pkg::NUM_CH-1:0] module_channel_fault_word_out,
  output logic [wire_off_pkg::NUM_CH-1:0] channel_below_range_flag_out,
  output logic [wire_off_pkg::NUM_CH-1:0] channel_above_range_flag_out
);
  import wire_off_pkg::*;
  ////////////////////////////////////////////////////////////////////
  // reset release
  logic [1:0] rst_sync_ff; // release shifter
  logic rst_n; // synchronised reset
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];
  ////////////////////////////////////////////////////////////////////
  // detector synchronisers
  logic [NUM_CH-1:0] sig_meta_ff; // first stage only
  logic [NUM_CH-1:0] sig_off_ff; // usable copy
  logic [NUM_CH-1:0] rtb_meta_ff; // first stage only
  logic [NUM_CH-1:0] rtb_off_ff; // usable copy
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sig_meta_ff <= '0;
      sig_off_ff <= '0;
      rtb_meta_ff <= '0;
      rtb_off_ff <= '0;
    end else if (clk_en_in) begin
      sig_meta_ff <= sig_wire_off_in;
      sig_off_ff <= sig_meta_ff;
      rtb_meta_ff <= removable_terminal_block_off_in;
      rtb_off_ff <= rtb_meta_ff;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // registers
  logic [3:0] config_ff; // wiring mode and format
  logic [31:0] fmin_ff; // float minimum scaled value
  logic [31:0] fmax_ff; // float maximum scaled value
  logic [NUM_CH-1:0] valid_mask; // channel slots in use
  ////////////////////////////////////////////////////////////////////
  // channel slots in use per wiring mode
  always_comb begin
    valid_mask = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (!config_ff[CFG_DIFF_BIT]) begin
        valid_mask[i] = 1'b1; // single-ended: sixteen
      end else if (config_ff[CFG_HS_BIT]) begin
        valid_mask[i] = (i < 8) && (i % 2 == 0);
      end else begin
        valid_mask[i] = (i < 8); // differential: eight
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // channel instances
  logic [31:0] ch_data [NUM_CH]; // per-channel reported data
  logic [NUM_CH-1:0] ch_below; // raw below flags
  logic [NUM_CH-1:0] ch_above; // raw above flags
  // full open: terminal block pulled, masked to the channel slots in use
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    wire_off_channel u_ch (
      .clk_in(core_clk_in),
      .rst_n_in(rst_n),
      .ce_in(clk_en_in),
      .diff_in(config_ff[CFG_DIFF_BIT]),
      .curr_in(config_ff[CFG_CURR_BIT]),
      .float_in(config_ff[CFG_FLOAT_BIT]),
      .odd_in(g % 2 == 1),
      .fmin_in(fmin_ff),
      .fmax_in(fmax_ff),
      .upd_in(sample_valid_in && sample_ch_in == CH_W'(g)),
      .sig_off_in(sig_off_ff[g] && valid_mask[g]),
      .full_off_in(rtb_off_ff[g] && valid_mask[g]),
      .raw_in(sample_data_in),
      .raw_below_in(sample_below_in),
      .raw_above_in(sample_above_in),
      .data_out(ch_data[g]),
      .below_out(ch_below[g]),
      .above_out(ch_above[g])
    );
  end
  ////////////////////////////////////////////////////////////////////
  // flags and fault word to the owner
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      channel_below_range_flag_out <= '0;
      channel_above_range_flag_out <= '0;
      module_channel_fault_word_out <= '0;
    end else if (clk_en_in) begin
      channel_below_range_flag_out <= ch_below & valid_mask;
      channel_above_range_flag_out <= ch_above & valid_mask;
      module_channel_fault_word_out <= (ch_below | ch_above) & valid_mask;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // ahb address phase capture
  logic dphase_ff; // data phase pending
  logic dwrite_ff; // pending is a write
  logic [7:0] daddr_ff; // pending address
  logic take; // valid address phase
  assign take = hsel_in && hready_in && htrans_in[1] && clk_en_in;
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      dphase_ff <= 1'b0;
      dwrite_ff <= 1'b0;
      daddr_ff <= 8'h00;
    end else if (clk_en_in) begin
      dphase_ff <= take;
      if (take) begin
        dwrite_ff <= hwrite_in;
        daddr_ff <= haddr_in;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // register writes in data phase
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      config_ff <= CONFIG_RST;
      fmin_ff <= FMIN_RST;
      fmax_ff <= FMAX_RST;
    end else if (clk_en_in && dphase_ff && dwrite_ff) begin
      case (daddr_ff)
        CONFIG_OFF: config_ff <= hwdata_in[3:0];
        FMIN_OFF: fmin_ff <= hwdata_in;
        FMAX_OFF: fmax_ff <= hwdata_in;
        default: config_ff <= config_ff; // unmapped or read-only
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////
  // read mux, registered at address phase
  logic [31:0] nxt_rdata; // read value
  logic fwd; // write to the same word still in its data phase
  // a pipelined read behind a write must see the new value, not the stale one
  assign fwd = dphase_ff && dwrite_ff && (daddr_ff == haddr_in);
  always_comb begin
    nxt_rdata = 32'h00000000;
    if (haddr_in >= DATA_BASE) begin
      nxt_rdata = ch_data[haddr_in[5:2]]; // channel data words
    end else begin
      case (haddr_in)
        CONFIG_OFF: nxt_rdata = fwd ? {28'h0000000, hwdata_in[3:0]} : {28'h0000000, config_ff};
        FAULT_OFF: nxt_rdata = {16'h0000, module_channel_fault_word_out};
        BELOW_OFF: nxt_rdata = {16'h0000, channel_below_range_flag_out};
        ABOVE_OFF: nxt_rdata = {16'h0000, channel_above_range_flag_out};
        FMIN_OFF: nxt_rdata = fwd ? hwdata_in : fmin_ff; // forwarded when pending
        FMAX_OFF: nxt_rdata = fwd ? hwdata_in : fmax_ff; // forwarded when pending
        default: nxt_rdata = 32'h00000000; // unmapped reads zero
      endcase
    end
  end
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_out <= 32'h00000000;
    end else if (take && !hwrite_in) begin
      hrdata_out <= nxt_rdata;
    end
  end
  // zero-wait slave, always okay
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // checks
  fault_word_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    clk_en_in |=> module_channel_fault_word_out ==
    (($past(ch_below) | $past(ch_above)) & $past(valid_mask)))
    else $error("fault word mismatch");
  hs_mask_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (config_ff[CFG_DIFF_BIT] && config_ff[CFG_HS_BIT]) |-> valid_mask == 16'h0055)
    else $error("high speed mask wrong");
  flag_b_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (clk_en_in && |(ch_below & valid_mask)) |=> |channel_below_range_flag_out)
    else $error("below flag lost");
  fault_c: cover property (@(posedge core_clk_in) disable iff (!rst_n)
    |module_channel_fault_word_out);
  write_c: cover property (@(posedge core_clk_in) disable iff (!rst_n)
    dphase_ff && dwrite_ff && daddr_ff == CONFIG_OFF);
endmodule // wire_off_detect

// ### testbench/owner_ctrl_model.sv
// Purpose: owner controller model watching the multicast fault ports
// Assumes: fault word and range flags are registered levels
// Notes: tallies fault word mismatches lasting two cycles, read by the bench
`timescale 1ns/1ps
module owner_ctrl_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // multicast status from the module
  input wire logic [wire_off_pkg::NUM_CH-1:0] fault_in,
  input wire logic [wire_off_pkg::NUM_CH-1:0] below_in,
  input wire logic [wire_off_pkg::NUM_CH-1:0] above_in,
  // tally for the bench
  output int bad_out
);
  import wire_off_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  logic miss_ff = 1'b0; // mismatch seen last cycle
  int bad_cnt = 0; // running tally, survives a mid-run reset
  assign bad_out = bad_cnt;
  // one-cycle skew between flag and word is tolerated, two cycles is not
  always @(posedge clk_in) begin
    miss_ff <= rst_n_in && (fault_in !== (below_in | above_in));
    if (miss_ff && rst_n_in && (fault_in !== (below_in | above_in))) begin
      bad_cnt <= bad_cnt + 1;
    end
  end
endmodule // owner_ctrl_model

// ### testbench/testbench.sv
// Purpose: self-checking bench for the wire-off detect block
// Assumes: zero wait AHB-Lite slave, 2-flop synced wire-off pins
// Notes: table rows for substitutions, hand tests for reset and enable
`timescale 1ns/1ps
module testbench;
  import wire_off_pkg::*;
  typedef struct packed {
    logic [3:0] cfg; logic [3:0] ch; logic sig; logic full;
    logic [31:0] raw; logic [31:0] exp; logic below; logic above; logic dchk;
  } row_t;
  localparam logic [31:0] FMIN_V = 32'hC1200000; // software float minimum
  localparam logic [31:0] FMAX_V = 32'h41200000; // software float maximum
  localparam logic [31:0] RAW_V = 32'h00000123; // plain in-range reading
  localparam row_t ROWS [18] = '{
    '{4'h0, 4'h1, 1'b1, 1'b0, RAW_V, INT_SE_MIN, 1'b1, 1'b0, 1'b1},
    '{4'h0, 4'h1, 1'b1, 1'b0, 32'h00000124, INT_SE_MIN, 1'b1, 1'b0, 1'b1},
    '{4'h0, 4'h1, 1'b0, 1'b0, 32'h00000055, 32'h00000055, 1'b0, 1'b1, 1'b1},
    '{4'h0, 4'h2, 1'b1, 1'b0, RAW_V, INT_SE_MAX, 1'b0, 1'b1, 1'b1},
    '{4'h0, 4'hF, 1'b0, 1'b1, RAW_V, INT_SE_MIN, 1'b1, 1'b0, 1'b1},
    '{4'h0, 4'hE, 1'b0, 1'b1, RAW_V, INT_SE_MAX, 1'b0, 1'b1, 1'b1},
    '{4'h1, 4'h0, 1'b1, 1'b0, RAW_V, INT_DIFF_MAX, 1'b0, 1'b1, 1'b1},
    '{4'h2, 4'h4, 1'b1, 1'b0, RAW_V, INT_CUR_MIN, 1'b1, 1'b0, 1'b1},
    '{4'h3, 4'h5, 1'b1, 1'b0, RAW_V, INT_CUR_MIN, 1'b1, 1'b0, 1'b1},
    '{4'h2, 4'h6, 1'b0, 1'b1, RAW_V, INT_DIFF_MAX, 1'b0, 1'b1, 1'b1},
    '{4'h3, 4'h7, 1'b0, 1'b1, RAW_V, INT_DIFF_MAX, 1'b0, 1'b1, 1'b1},
    '{4'h4, 4'h3, 1'b1, 1'b0, RAW_V, FMIN_V, 1'b1, 1'b0, 1'b1},
    '{4'h4, 4'h8, 1'b1, 1'b0, RAW_V, FMAX_V, 1'b0, 1'b1, 1'b1},
    '{4'h5, 4'h1, 1'b1, 1'b0, RAW_V, FMAX_V, 1'b0, 1'b1, 1'b1},
    '{4'h6, 4'h2, 1'b1, 1'b0, RAW_V, FMIN_V, 1'b1, 1'b0, 1'b1},
    '{4'h6, 4'h9, 1'b0, 1'b1, RAW_V, FMAX_V, 1'b0, 1'b1, 1'b1},
    '{4'h9, 4'h3, 1'b1, 1'b0, RAW_V, 32'h0, 1'b0, 1'b0, 1'b0},
    '{4'h9, 4'h6, 1'b1, 1'b0, RAW_V, INT_DIFF_MAX, 1'b0, 1'b1, 1'b1}
  };
  ////////////////////////////////////////////////////////////////////////////////
  logic core_clk_in, reset_n_in, clk_en_in; // clock, reset, enable
  logic [7:0] haddr; // bus address
  logic [1:0] htrans; // bus transfer kind
  logic hwrite, hreadyout, hresp; // bus control
  logic [31:0] hwdata, hrdata, rd; // bus data
  logic [15:0] sig_off, full_off, fault, below, above; // pins and flags
  logic s_valid, s_below, s_above; // sample strobe and raw flags
  logic [3:0] s_ch; // sample channel
  logic [31:0] s_data; // sample reading
  int error_cnt, checks_done, cyc, bad; // tallies
  // design under test
  wire_off_detect dut (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
    .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(HSIZE_WORD), .hwdata_in(hwdata), .hready_in(hreadyout),
    .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp),
    .sig_wire_off_in(sig_off), .removable_terminal_block_off_in(full_off),
    .sample_valid_in(s_valid), .sample_ch_in(s_ch), .sample_data_in(s_data),
    .sample_below_in(s_below), .sample_above_in(s_above),
    .module_channel_fault_word_out(fault), .channel_below_range_flag_out(below),
    .channel_above_range_flag_out(above)
  );
  // owner side watcher
  owner_ctrl_model partner (
    .clk_in(core_clk_in), .rst_n_in(reset_n_in), .fault_in(fault),
    .below_in(below), .above_in(above), .bad_out(bad)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // compare helpers
  task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmp1(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %b got %b", nm, e, g);
    end
  endtask
  // single word transfer, address phase then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge core_clk_in); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk_in); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // one sample pulse, then wait until flag ports have landed
  task automatic sample(input logic [3:0] ch, input logic [31:0] d, input logic b, input logic a);
    s_valid <= 1'b1;
    s_ch <= ch;
    s_data <= d;
    s_below <= b;
    s_above <= a;
    @(posedge core_clk_in);
    s_valid <= 1'b0;
    repeat (3) @(posedge core_clk_in);
  endtask
  // one table row: mode, pins, sample, flags, data
  task automatic run_row(input row_t r);
    ahb(1'b1, CONFIG_OFF, {28'h0, r.cfg});
    sig_off <= 16'(r.sig) << r.ch;
    full_off <= 16'(r.full) << r.ch;
    repeat (3) @(posedge core_clk_in);
    sample(r.ch, r.raw, r.below & ~(r.sig | r.full), r.above & ~(r.sig | r.full));
    cmp1("below flag", r.below, below[r.ch]);
    cmp1("above flag", r.above, above[r.ch]);
    cmp1("fault bit", r.below | r.above, fault[r.ch]);
    ahb(1'b0, DATA_BASE + {2'h0, r.ch, 2'h0}, 32'h0);
    if (r.dchk) cmp32("channel data", r.exp, rd);
  endtask
  // register defaults after a reset
  task automatic check_reset();
    cmp1("hreadyout", 1'b1, hreadyout);
    cmp1("hresp", 1'b0, hresp);
    cmp32("fault word", 32'h0, {16'h0, fault});
    ahb(1'b0, CONFIG_OFF, 32'h0);
    cmp32("config", {28'h0, CONFIG_RST}, rd);
    ahb(1'b0, FMIN_OFF, 32'h0);
    cmp32("fmin", FMIN_RST, rd);
    ahb(1'b1, 8'h38, 32'hFFFFFFFF);
    ahb(1'b0, 8'h38, 32'h0);
    cmp32("unmapped", 32'h0, rd);
  endtask
  // verdict and end of run
  task automatic close_out();
    error_cnt += bad;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end
  // hang guard
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  // main sequence
  initial begin
    {reset_n_in, clk_en_in, haddr, htrans, hwrite, hwdata} = '0;
    {sig_off, full_off, s_valid, s_ch, s_data, s_below, s_above} = '0;
    clk_en_in = 1'b1;
    repeat (20) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    check_reset();
    ahb(1'b1, FMIN_OFF, FMIN_V);
    ahb(1'b1, FMAX_OFF, FMAX_V);
    ahb(1'b0, FMAX_OFF, 32'h0);
    cmp32("fmax", FMAX_V, rd);
    foreach (ROWS[i]) run_row(ROWS[i]);
    // frozen enable takes no sample
    ahb(1'b1, CONFIG_OFF, 32'h0);
    sig_off <= 16'h0400;
    full_off <= 16'h0;
    repeat (3) @(posedge core_clk_in);
    clk_en_in <= 1'b0;
    sample(4'hA, RAW_V, 1'b0, 1'b0);
    cmp1("frozen above", 1'b0, above[10]);
    clk_en_in <= 1'b1;
    sample(4'hA, RAW_V, 1'b0, 1'b0);
    cmp1("enabled above", 1'b1, above[10]);
    // reset in mid-run clears flags and registers
    reset_n_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    check_reset();
    close_out();
  end
endmodule // testbench
